// *** pkg/udc_pkg.sv ***
// Constants and types for the upper DMA channel register set
`default_nettype none
package udc_pkg;
  // ***************************************************************
  // I/O port addresses
  // ***************************************************************
  localparam logic [15:0] PORT_CH4_ADDR = 16'h00c0;
  localparam logic [15:0] PORT_CH4_CNT = 16'h00c2;
  localparam logic [15:0] PORT_CH5_ADDR = 16'h00c4;
  localparam logic [15:0] PORT_CH5_CNT = 16'h00c6;
  localparam logic [15:0] PORT_CH6_ADDR = 16'h00c8;
  localparam logic [15:0] PORT_CH6_CNT = 16'h00ca;
  localparam logic [15:0] PORT_CH7_ADDR = 16'h00cc;
  localparam logic [15:0] PORT_CH7_CNT = 16'h00ce;
  localparam logic [15:0] PORT_STAT_CTRL = 16'h00d0;
  localparam logic [15:0] PORT_SW_REQ = 16'h00d2;
  localparam logic [15:0] PORT_CLR_PTR = 16'h00d8;
  // ***************************************************************
  // Control field positions and reset values
  // ***************************************************************
  localparam int CTL_ACK_POL = 7;
  localparam int CTL_REQ_POL = 6;
  localparam int CTL_EARLY_WR = 5;
  localparam int CTL_ROT_PRI = 4;
  localparam int CTL_COMP_TIM = 3;
  localparam int CTL_DISABLE = 2;
  localparam int CTL_ADDR_HOLD = 1;
  localparam int CTL_MEM_COPY = 0;
  localparam int SWR_VALUE = 2;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam int NUM_CH = 4;
  localparam int PAGE_W = 10;
  localparam int DMA_ADDR_W = 26;
  // Byte pointer state
  typedef enum logic [1:0] {
    UDC_PTR_LOW = 2'b01,
    UDC_PTR_HIGH = 2'b10
  } udc_ptr_e;
endpackage : udc_pkg
`default_nettype wire

// *** pkg/udc_ch_if.sv ***
// Interface carrying one channel's register access between modules
`default_nettype none
interface udc_ch_if;
  logic wr_addr;
  logic wr_cnt;
  logic high_byte;
  logic [7:0] wdata;
  logic [15:0] addr;
  logic [15:0] cnt;
  modport ctrl(output wr_addr, output wr_cnt, output high_byte, output wdata,
    input addr, input cnt);
  modport chan(input wr_addr, input wr_cnt, input high_byte, input wdata,
    output addr, output cnt);
endinterface : udc_ch_if
`default_nettype wire

// *** hw/udc_channel.sv ***
// One channel's 16-bit memory address and transfer count registers
`default_nettype none
module udc_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  udc_ch_if.chan bus
);
  logic [15:0] addr_q;
  logic [15:0] cnt_q;
  logic [15:0] next_addr;
  logic [15:0] next_cnt;

  // Byte-wide loads into the selected half
  always_comb begin
    next_addr = addr_q;
    next_cnt = cnt_q;
    if (bus.wr_addr) begin
      if (bus.high_byte) next_addr[15:8] = bus.wdata;
      else next_addr[7:0] = bus.wdata;
    end
    if (bus.wr_cnt) begin
      if (bus.high_byte) next_cnt[15:8] = bus.wdata;
      else next_cnt[7:0] = bus.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 16'h0000;
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      addr_q <= next_addr;
      cnt_q <= next_cnt;
    end
  end

  assign bus.addr = addr_q;
  assign bus.cnt = cnt_q;

  a_low_byte_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && bus.wr_addr && !bus.high_byte |=> addr_q[7:0] == $past(bus.wdata))
    else $error("address low byte not loaded");
endmodule : udc_channel
`default_nettype wire

// *** hw/udc_status.sv ***
// Status flags: live request bits and sticky terminal count bits
`default_nettype none
module udc_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] pend_i,
  input wire logic [3:0] tc_i,
  input wire logic rd_i,
  output logic [7:0] stat_o
);
  logic [3:0] tc_q;
  logic [3:0] next_tc;
  logic [3:0] pend_q;

  // Set wins over read clear so a count hit is never lost
  always_comb begin
    next_tc = tc_q;
    if (rd_i) next_tc = 4'h0;
    next_tc = next_tc | tc_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tc_q <= 4'h0;
      pend_q <= 4'h0;
    end else if (ce_i) begin
      tc_q <= next_tc;
      pend_q <= pend_i;
    end
  end

  assign stat_o = {pend_q, tc_q};

  a_read_clears_tc: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_i && tc_i == 4'h0 |=> tc_q == 4'h0)
    else $error("status read did not clear terminal counts");
  a_tc_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !rd_i |=> (tc_q & $past(tc_q)) == $past(tc_q))
    else $error("terminal count lost without read");
endmodule : udc_status
`default_nettype wire

// *** hw/udc_regs.sv ***
// Upper DMA controller register set, channels 4 to 7
`default_nettype none
module udc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [3:0] dreq_i,
  input wire logic [3:0] tc_i,
  input wire logic [3:0] dack_i,
  input wire logic [2:0] grant_ch_i,
  input wire logic [19:0] page_lo_i,
  input wire logic [19:0] page_hi_i,
  output logic [7:0] io_rdata_o,
  output logic io_hit_o,
  output logic [3:0] req_o,
  output logic [3:0] dack_o,
  output logic early_write_o,
  output logic rotating_priority_o,
  output logic compressed_timing_o,
  output logic source_address_hold_o,
  output logic [25:0] dma_addr_o,
  output logic [15:0] dma_count_o
);
  // ***************************************************************
  // Decode and byte pointer
  // ***************************************************************
  logic [7:0] ctrl_q;
  logic [7:0] next_ctrl;
  logic [3:0] swreq_q;
  logic [3:0] next_swreq;
  udc_pkg::udc_ptr_e ptr_q;
  udc_pkg::udc_ptr_e next_ptr;
  logic [3:0] sel_addr;
  logic [3:0] sel_cnt;
  logic hit_stat;
  logic hit_swr;
  logic hit_clr;
  logic stat_rd;
  logic [7:0] stat;
  logic [3:0] req_raw;
  logic [3:0] pend;
  logic [15:0] ch_addr [4];
  logic [15:0] ch_cnt [4];

  // Address decode for the channel ports
  always_comb begin
    sel_addr = 4'h0;
    sel_cnt = 4'h0;
    if (io_addr_i == udc_pkg::PORT_CH4_ADDR) sel_addr[0] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH4_CNT) sel_cnt[0] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH5_ADDR) sel_addr[1] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH5_CNT) sel_cnt[1] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH6_ADDR) sel_addr[2] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH6_CNT) sel_cnt[2] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH7_ADDR) sel_addr[3] = 1'b1;
    else if (io_addr_i == udc_pkg::PORT_CH7_CNT) sel_cnt[3] = 1'b1;
  end

  assign hit_stat = (io_addr_i == udc_pkg::PORT_STAT_CTRL);
  assign hit_swr = (io_addr_i == udc_pkg::PORT_SW_REQ);
  assign hit_clr = (io_addr_i == udc_pkg::PORT_CLR_PTR);
  assign stat_rd = io_rd_i && hit_stat;

  // ***************************************************************
  // Channel register instances
  // ***************************************************************
  for (genvar g = 0; g < udc_pkg::NUM_CH; g++) begin : g_ch
    udc_ch_if chb();
    assign chb.wr_addr = io_wr_i && sel_addr[g];
    assign chb.wr_cnt = io_wr_i && sel_cnt[g];
    assign chb.high_byte = (ptr_q == udc_pkg::UDC_PTR_HIGH);
    assign chb.wdata = io_wdata_i;
    assign ch_addr[g] = chb.addr;
    assign ch_cnt[g] = chb.cnt;
    udc_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .bus(chb)
    );
  end

  // ***************************************************************
  // Control, software request and pointer
  // ***************************************************************
  // Pointer flips on each channel byte; a clear-pointer write resets it
  always_comb begin
    next_ctrl = ctrl_q;
    next_swreq = swreq_q;
    next_ptr = ptr_q;
    if (io_wr_i && hit_stat) next_ctrl = io_wdata_i;
    if (io_wr_i && hit_swr) begin
      next_swreq[io_wdata_i[1:0]] = io_wdata_i[udc_pkg::SWR_VALUE];
    end
    if (io_wr_i && hit_clr) next_ptr = udc_pkg::UDC_PTR_LOW;
    else if ((io_wr_i || io_rd_i) && ((sel_addr | sel_cnt) != 4'h0)) begin
      case (ptr_q)
        udc_pkg::UDC_PTR_LOW: next_ptr = udc_pkg::UDC_PTR_HIGH;
        udc_pkg::UDC_PTR_HIGH: next_ptr = udc_pkg::UDC_PTR_LOW;
        default: next_ptr = udc_pkg::UDC_PTR_LOW;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= udc_pkg::CTL_RESET;
      swreq_q <= 4'h0;
      ptr_q <= udc_pkg::UDC_PTR_LOW;
    end else if (ce_i) begin
      ctrl_q <= next_ctrl;
      swreq_q <= next_swreq;
      ptr_q <= next_ptr;
    end
  end

  // ***************************************************************
  // Request qualification and status
  // ***************************************************************
  // Polarity is applied before the pending view so status is always active high
  assign req_raw = ctrl_q[udc_pkg::CTL_REQ_POL] ? ~dreq_i : dreq_i;
  assign pend = req_raw | swreq_q;

  udc_status u_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pend_i(pend),
    .tc_i(tc_i),
    .rd_i(stat_rd),
    .stat_o(stat)
  );

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  logic [7:0] next_rdata;
  logic next_hit;
  logic [3:0] next_req;
  logic [3:0] next_dack;
  logic [25:0] next_dma_addr;
  logic [15:0] next_dma_count;
  logic [1:0] gsel;

  // Read mux; unmapped ports return zero and no hit
  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    for (int i = 0; i < udc_pkg::NUM_CH; i++) begin
      if (sel_addr[i] && io_rd_i) begin
        next_rdata = (ptr_q == udc_pkg::UDC_PTR_HIGH) ? ch_addr[i][15:8] : ch_addr[i][7:0];
        next_hit = 1'b1;
      end
      if (sel_cnt[i] && io_rd_i) begin
        next_rdata = (ptr_q == udc_pkg::UDC_PTR_HIGH) ? ch_cnt[i][15:8] : ch_cnt[i][7:0];
        next_hit = 1'b1;
      end
    end
    if (stat_rd) begin
      next_rdata = stat;
      next_hit = 1'b1;
    end
    if ((io_wr_i || io_rd_i) && (hit_stat || hit_swr || hit_clr)) next_hit = 1'b1;
  end

  // Disable gates requests only; register access continues
  assign gsel = grant_ch_i[1:0];
  always_comb begin
    next_req = ctrl_q[udc_pkg::CTL_DISABLE] ? 4'h0 : pend;
    next_dack = ctrl_q[udc_pkg::CTL_ACK_POL] ? dack_i : ~dack_i;
    next_dma_addr = {(gsel[1] ? page_hi_i[gsel[0]*10 +: 10] : page_lo_i[gsel[0]*10 +: 10]),
      ch_addr[gsel]};
    next_dma_count = ch_cnt[gsel];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o <= 8'h00;
      io_hit_o <= 1'b0;
      req_o <= 4'h0;
      dack_o <= 4'hf;
      early_write_o <= 1'b0;
      rotating_priority_o <= 1'b0;
      compressed_timing_o <= 1'b0;
      source_address_hold_o <= 1'b0;
      dma_addr_o <= 26'h0000000;
      dma_count_o <= 16'h0000;
    end else if (ce_i) begin
      io_rdata_o <= next_rdata;
      io_hit_o <= next_hit;
      req_o <= next_req;
      dack_o <= next_dack;
      early_write_o <= ctrl_q[udc_pkg::CTL_EARLY_WR];
      rotating_priority_o <= ctrl_q[udc_pkg::CTL_ROT_PRI];
      compressed_timing_o <= ctrl_q[udc_pkg::CTL_COMP_TIM];
      // Hold only matters with memory copy on, otherwise forced off
      source_address_hold_o <= ctrl_q[udc_pkg::CTL_ADDR_HOLD] &&
        ctrl_q[udc_pkg::CTL_MEM_COPY];
      dma_addr_o <= next_dma_addr;
      dma_count_o <= next_dma_count;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_disable_set;
    ce_i && ctrl_q[udc_pkg::CTL_DISABLE];
  endsequence
  sequence s_disable_held;
    s_disable_set ##1 ce_i;
  endsequence

  a_disable_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    s_disable_held |-> req_o == 4'h0)
    else $error("requests passed while disabled");
  a_hold_needs_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    source_address_hold_o |-> $past(ctrl_q[udc_pkg::CTL_MEM_COPY]))
    else $error("address hold active without memory copy");
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && io_wr_i && hit_stat |=> ctrl_q == $past(io_wdata_i))
    else $error("control write not stored");
  a_swreq_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && io_wr_i && hit_swr |=> swreq_q[$past(io_wdata_i[1:0])] == $past(io_wdata_i[2]))
    else $error("software request latch wrong");
  a_ack_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ctrl_q[udc_pkg::CTL_ACK_POL] |=> dack_o == ~$past(dack_i))
    else $error("acknowledge not active low");
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && stat_rd |=> io_rdata_o == $past(stat) && io_hit_o)
    else $error("status read data wrong");
  a_early_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> early_write_o == $past(ctrl_q[udc_pkg::CTL_EARLY_WR]))
    else $error("early write select not followed");
  a_req_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ctrl_q[udc_pkg::CTL_REQ_POL] && !ctrl_q[udc_pkg::CTL_DISABLE]
    && swreq_q == 4'h0 |=> req_o == $past(dreq_i))
    else $error("request polarity wrong");
  a_ptr_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && io_wr_i && sel_cnt != 4'h0 |=> ptr_q != $past(ptr_q))
    else $error("byte pointer did not toggle");
endmodule : udc_regs
`default_nettype wire

// *** dv/udc_periph_model.sv ***
// Behavioural model of the DMA-capable peripherals on the request side
`default_nettype none
module udc_periph_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] want_i,
  input wire logic req_low_i,
  input wire logic ack_high_i,
  input wire logic [3:0] dack_i,
  output logic [3:0] dreq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pend;
  logic [3:0] ack_seen;
  // ***************************************************************
  // Request lines
  // ***************************************************************
  // Acknowledge read in the sense the system was told to use
  assign ack_seen = ack_high_i ? dack_i : ~dack_i;
  // A request drops once acknowledged, like a real demand peripheral
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= 4'h0;
    end else begin
      pend <= want_i & ~ack_seen;
    end
  end
  // Lines driven in the programmed sense
  assign dreq_o = req_low_i ? ~pend : pend;
endmodule : udc_periph_model
`default_nettype wire

// *** dv/udc_regs_bench.sv ***
// Self-checking bench for the upper DMA channel register set
`default_nettype none
module udc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [3:0] dreq;
  logic [3:0] tc = 4'h0;
  logic [3:0] dack = 4'h0;
  logic [2:0] grant = 3'h0;
  logic [19:0] page_lo = {10'h2b5, 10'h14a};
  logic [19:0] page_hi = {10'h3c3, 10'h0f0};
  logic [3:0] want = 4'h0;
  logic req_low = 1'b0;
  logic ack_high = 1'b0;
  logic [7:0] rdata;
  logic hit;
  logic [3:0] req;
  logic [3:0] dack_pin;
  logic early_wr;
  logic rot_pri;
  logic comp_tim;
  logic addr_hold;
  logic [25:0] dma_addr;
  logic [15:0] dma_count;
  logic [7:0] ctl_tab [6] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h03, 8'h00};
  int errors = 0;
  int checked = 0;

  // ***************************************************************
  // Clock, design and partner
  // ***************************************************************
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  udc_regs u_udc_regs (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .io_addr_i(io_addr),
    .io_rd_i(io_rd), .io_wr_i(io_wr), .io_wdata_i(io_wdata), .dreq_i(dreq), .tc_i(tc),
    .dack_i(dack), .grant_ch_i(grant), .page_lo_i(page_lo), .page_hi_i(page_hi),
    .io_rdata_o(rdata), .io_hit_o(hit), .req_o(req), .dack_o(dack_pin),
    .early_write_o(early_wr), .rotating_priority_o(rot_pri),
    .compressed_timing_o(comp_tim), .source_address_hold_o(addr_hold),
    .dma_addr_o(dma_addr), .dma_count_o(dma_count));

  udc_periph_model u_udc_periph_model (.clk_i(clk), .rst_i(rst), .want_i(want),
    .req_low_i(req_low), .ack_high_i(ack_high), .dack_i(dack_pin), .dreq_o(dreq));

  // ***************************************************************
  // Access and compare tasks
  // ***************************************************************
  // Mismatch reporting and counting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobe, raised and dropped at falling edges
  task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = ~wr;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io_acc

  // Read data stands in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    io_acc(1'b0, a, 8'h00);
    check(32'(rdata), 32'(exp));
  endtask : rd

  // Bounded wait for the qualified request vector
  task automatic wait_req(input logic [3:0] exp);
    int n;
    n = 0;
    while (req !== exp && n < 8) begin
      @(negedge clk);
      n++;
    end
    check(32'(req), 32'(exp));
  endtask : wait_req

  // Distinct byte pattern per channel and port kind
  function automatic logic [15:0] pat(input int c, input int k);
    return {8'(160 + c * 2 + k), 8'(48 + c * 2 + k)};
  endfunction : pat

  task automatic conclude;
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(32'(dack_pin), 32'h0000000f);
    rd(udc_pkg::PORT_STAT_CTRL, 8'h00);
    check(32'(hit), 32'h1);
    rd(16'h00e0, 8'h00);
    check(32'(hit), 32'h0);
    // Both bytes of every address and count port, low byte first, controller off meanwhile
    io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, 8'h04);
    io_acc(1'b1, udc_pkg::PORT_CLR_PTR, 8'h00);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        io_acc(1'b1, 16'(192 + c * 4 + k * 2), 8'(pat(c, k)));
        io_acc(1'b1, 16'(192 + c * 4 + k * 2), 8'(pat(c, k) >> 8));
      end
    end
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        rd(16'(192 + c * 4 + k * 2), 8'(pat(c, k)));
        rd(16'(192 + c * 4 + k * 2), 8'(pat(c, k) >> 8));
      end
      grant = 3'(c);
      repeat (2) @(negedge clk);
      check(32'(dma_count), 32'(pat(c, 1)));
      check(32'(dma_addr), 32'({10'({page_hi, page_lo} >> (10 * c)), pat(c, 0)}));
    end
    // Control fields that reach their own outputs
    foreach (ctl_tab[i]) begin
      io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, ctl_tab[i]);
      @(negedge clk);
      check(32'({early_wr, rot_pri, comp_tim, addr_hold}),
        32'({ctl_tab[i][5], ctl_tab[i][4], ctl_tab[i][3], ctl_tab[i][1] & ctl_tab[i][0]}));
    end
    // Hardware request on channel 5, then global disable
    want = 4'h2;
    wait_req(4'h2);
    repeat (2) @(negedge clk);
    rd(udc_pkg::PORT_STAT_CTRL, 8'h20);
    io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, 8'h04);
    wait_req(4'h0);
    rd(udc_pkg::PORT_CH4_CNT, 8'(pat(0, 1)));
    rd(udc_pkg::PORT_CH4_CNT, 8'(pat(0, 1) >> 8));
    // Low-true requests, then acknowledge makes the peripheral let go
    io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, 8'h40);
    req_low = 1'b1;
    wait_req(4'h2);
    dack = 4'h2;
    repeat (2) @(negedge clk);
    check(32'(dack_pin), 32'h0000000d);
    wait_req(4'h0);
    io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, 8'h80);
    ack_high = 1'b1;
    repeat (2) @(negedge clk);
    check(32'(dack_pin), 32'h00000002);
    want = 4'h0;
    dack = 4'h0;
    io_acc(1'b1, udc_pkg::PORT_STAT_CTRL, 8'h00);
    req_low = 1'b0;
    ack_high = 1'b0;
    wait_req(4'h0);
    // Software request per channel with a terminal count alongside
    for (int c = 0; c < 4; c++) begin
      io_acc(1'b1, udc_pkg::PORT_SW_REQ, 8'(4 + c));
      wait_req(4'(1 << c));
      @(negedge clk);
      tc = 4'(1 << c);
      @(negedge clk);
      tc = 4'h0;
      rd(udc_pkg::PORT_STAT_CTRL, 8'(17 << c));
      rd(udc_pkg::PORT_STAT_CTRL, 8'(16 << c));
      io_acc(1'b1, udc_pkg::PORT_SW_REQ, 8'(c));
      wait_req(4'h0);
    end
    conclude();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : udc_regs_bench
`default_nettype wire
